//--- cfbp_cfg.svh
`ifndef CFBP_CFG_SVH
`define CFBP_CFG_SVH
`define CFBP_WORD_W 32
`define CFBP_BW_W 16
`define CFBP_PREFIX 32'hFFFFFFFF
`define CFBP_CODE_FIRST_FIELD_START_CODE 8'h40
`define CFBP_CODE_SECOND_FIELD_START_CODE 8'h41
`define CFBP_CODE_SOB1 8'h81
`define CFBP_CODE_SOB4 8'h84
`define CFBP_CODE_ZERO 8'h8F
`define CFBP_CODE_EOS 8'hC0
`define CFBP_EOS_TAIL 32'hC0FFFFFF
`define CFBP_SOF_TAIL 24'h000000
`define CFBP_PAD_BYTE 8'hFF
`define CFBP_BW_ZERO 16'h0000
`define CFBP_FIELD_BLOCKS 41
`define CFBP_CODE_MSB 31
`define CFBP_CODE_LSB 24
`define CFBP_BW_MSB 23
`define CFBP_BW_LSB 8
`define CFBP_FULL_BITS 6'h20
`endif

//--- cfbp_dev.sv
`timescale 1ns/100ps
`include "cfbp_cfg.svh"
module cfbp_dev #(
  parameter int FIELD_BLOCKS = `CFBP_FIELD_BLOCKS
) (
  input wire logic sys_clk,
  input wire logic resetn,
  cfbp_if.dev link,
  input wire logic enc_mode,
  input wire logic huff_busy,
  output logic [`CFBP_WORD_W-1:0] dec_data_q,
  output logic dec_first_q,
  output logic dec_valid_q,
  input wire logic dec_ready,
  output logic [`CFBP_BW_W-1:0] quant_scale_q,
  output logic quant_load_q,
  output logic [2:0] block_model_q,
  output logic block_start_q,
  output logic block_zero_q,
  output logic [5:0] block_count_q,
  output logic field_start_q,
  output logic field_second_q,
  output logic field_short_q,
  output logic seq_end_q,
  output logic huff_reset_q,
  input wire logic enc_cmd_valid,
  input wire cfbp_pkg::cfbp_cmd_type enc_cmd,
  input wire logic [7:0] enc_cmd_code,
  input wire logic [`CFBP_BW_W-1:0] enc_cmd_bw,
  input wire logic [`CFBP_BW_W-1:0] enc_cmd_recip,
  output logic enc_cmd_ready_q,
  input wire logic [`CFBP_WORD_W-1:0] enc_data,
  input wire logic [5:0] enc_nbits,
  input wire logic enc_last,
  input wire logic enc_valid,
  output logic enc_ready_q
);
  // Block counter is six bits wide
  if (FIELD_BLOCKS < 1 || FIELD_BLOCKS > 63) begin : g_bad_blocks
    $error("cfbp_dev: FIELD_BLOCKS out of range");
  end

  function automatic logic cfbp_known(input logic [7:0] c);
    cfbp_known = (c == `CFBP_CODE_FIRST_FIELD_START_CODE) || (c == `CFBP_CODE_SECOND_FIELD_START_CODE) || (c == `CFBP_CODE_ZERO) ||
      (c == `CFBP_CODE_EOS) || ((c >= `CFBP_CODE_SOB1) && (c <= `CFBP_CODE_SOB4));
  endfunction

  // ----------------------------------------
  // Decode input stage
  // ----------------------------------------
  cfbp_pkg::cfbp_dec_st_type dst_q;
  logic [`CFBP_WORD_W-1:0] hold_q;
  logic hold_full_q;
  logic pend_q;
  logic h2d_ready_q;
  wire in_take = link.h2d_valid && h2d_ready_q;
  wire pay_free = !dec_valid_q || dec_ready;
  wire step = hold_full_q && pay_free && !enc_mode;
  wire is_pre = (hold_q == `CFBP_PREFIX);
  wire [7:0] code = hold_q[`CFBP_CODE_MSB:`CFBP_CODE_LSB];
  wire [`CFBP_BW_W-1:0] blk_bw = hold_q[`CFBP_BW_MSB:`CFBP_BW_LSB];
  wire known = cfbp_known(code);
  wire delim = step && pend_q && !is_pre && known;
  wire pend_flush = step && pend_q && !is_pre && !known;
  wire consume = step && !pend_flush;
  wire is_sof = (code == `CFBP_CODE_FIRST_FIELD_START_CODE) || (code == `CFBP_CODE_SECOND_FIELD_START_CODE);
  wire is_sob = (code >= `CFBP_CODE_SOB1) && (code <= `CFBP_CODE_SOB4);
  wire is_zero = (code == `CFBP_CODE_ZERO);
  wire is_eos = (code == `CFBP_CODE_EOS);
  wire live = (dst_q != cfbp_pkg::CFBP_D_IDLE);
  wire sob_take = delim && live && is_sob;
  wire zero_take = delim && live && is_zero;
  wire sob_keep = sob_take && (blk_bw != `CFBP_BW_ZERO);
  wire plain_pay = step && !pend_q && !is_pre;
  wire pad_pay = step && pend_q && (is_pre || !known);
  wire in_block = (dst_q == cfbp_pkg::CFBP_D_BLOCK);
  wire emit = ((plain_pay || pad_pay) && in_block) || sob_keep;
  wire [`CFBP_WORD_W-1:0] emit_word = (plain_pay || sob_keep) ? hold_q : `CFBP_PREFIX;
  wire hold_full_d = in_take || (hold_full_q && !consume);
  wire abort_hit = delim && live && huff_busy && (is_sob || is_zero || is_eos);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hold_q <= 32'h00000000;
      hold_full_q <= 1'b0;
      h2d_ready_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      if (in_take) begin
        hold_q <= link.h2d_data;
      end
      hold_full_q <= hold_full_d;
      h2d_ready_q <= !hold_full_d;
      if (step && !pend_q && is_pre) begin
        pend_q <= 1'b1;
      end else if (delim || pend_flush) begin
        pend_q <= 1'b0;
      end
    end
  end
  assign link.h2d_ready = h2d_ready_q;

  // ----------------------------------------
  // Decode state and events
  // ----------------------------------------
  cfbp_pkg::cfbp_dec_st_type dst_d;
  always_comb begin
    dst_d = dst_q;
    if (delim) begin
      unique case (1'b1)
        is_sof: dst_d = cfbp_pkg::CFBP_D_FIELD;
        is_eos: dst_d = cfbp_pkg::CFBP_D_IDLE;
        is_zero: dst_d = live ? cfbp_pkg::CFBP_D_ZERO : dst_q;
        is_sob: dst_d = !live ? dst_q : (sob_keep ? cfbp_pkg::CFBP_D_BLOCK : cfbp_pkg::CFBP_D_ZERO);
        default: dst_d = dst_q;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dst_q <= cfbp_pkg::CFBP_D_IDLE;
      block_model_q <= 3'h0;
      block_start_q <= 1'b0;
      block_zero_q <= 1'b0;
      block_count_q <= 6'h00;
      field_start_q <= 1'b0;
      field_second_q <= 1'b0;
      field_short_q <= 1'b0;
      seq_end_q <= 1'b0;
      huff_reset_q <= 1'b0;
    end else begin
      dst_q <= dst_d;
      block_start_q <= sob_take || zero_take;
      block_zero_q <= zero_take || (sob_take && !sob_keep);
      field_start_q <= delim && is_sof;
      seq_end_q <= delim && is_eos;
      huff_reset_q <= (delim && is_sof) || abort_hit;
      field_short_q <= delim && (is_sof || is_eos) && live && (block_count_q != 6'(FIELD_BLOCKS));
      if (delim && is_sof) begin
        field_second_q <= (code == `CFBP_CODE_SECOND_FIELD_START_CODE);
        block_count_q <= 6'h00;
      end else if (sob_take || zero_take) begin
        block_count_q <= block_count_q + 6'h01;
        block_model_q <= sob_take ? code[2:0] : 3'h0;
      end
    end
  end

  // ----------------------------------------
  // Payload output and quantizer scale
  // ----------------------------------------
  cfbp_pkg::cfbp_enc_st_type est_q;
  logic enc_cmd_take;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dec_data_q <= 32'h00000000;
      dec_first_q <= 1'b0;
      dec_valid_q <= 1'b0;
      quant_scale_q <= 16'h0000;
      quant_load_q <= 1'b0;
    end else begin
      if (emit) begin
        dec_data_q <= emit_word;
        dec_first_q <= sob_keep;
        dec_valid_q <= 1'b1;
      end else if (dec_ready) begin
        dec_valid_q <= 1'b0;
      end
      quant_load_q <= sob_take || zero_take || (enc_cmd_take && enc_cmd == cfbp_pkg::CFBP_CMD_BLOCK);
      if (sob_take) begin
        quant_scale_q <= blk_bw;
      end else if (zero_take) begin
        quant_scale_q <= `CFBP_BW_ZERO;
      end else if (enc_cmd_take && enc_cmd == cfbp_pkg::CFBP_CMD_BLOCK) begin
        quant_scale_q <= enc_cmd_recip;
      end
    end
  end

  // ----------------------------------------
  // Encode framer
  // ----------------------------------------
  logic [7:0] ecode_q;
  logic [`CFBP_BW_W-1:0] ebw_q;
  logic eblk_q;
  logic [`CFBP_WORD_W-1:0] buf_q [2];
  logic wp_q;
  logic rp_q;
  logic [1:0] cnt_q;
  wire buf_room = (cnt_q != 2'h2);
  wire rd = link.d2h_valid && link.d2h_ready;
  wire pay_take = enc_valid && enc_ready_q;
  assign enc_cmd_take = enc_cmd_valid && enc_cmd_ready_q && enc_mode;
  wire hdr_wr = buf_room && ((est_q == cfbp_pkg::CFBP_E_PRE) || (est_q == cfbp_pkg::CFBP_E_HDR));
  wire wr = hdr_wr || pay_take;
  wire [`CFBP_WORD_W-1:0] pay_word = enc_last ? (enc_data | (`CFBP_PREFIX >> enc_nbits)) : enc_data;
  wire [`CFBP_WORD_W-1:0] hdr_word = eblk_q ? {ecode_q, ebw_q, `CFBP_PAD_BYTE} : {ecode_q, `CFBP_SOF_TAIL};
  wire [`CFBP_WORD_W-1:0] wr_word = (est_q == cfbp_pkg::CFBP_E_PRE) ? `CFBP_PREFIX :
    ((est_q == cfbp_pkg::CFBP_E_HDR) ? hdr_word : pay_word);
  wire [1:0] cnt_d = cnt_q + {1'b0, wr} - {1'b0, rd};
  cfbp_pkg::cfbp_enc_st_type est_d;
  always_comb begin
    est_d = est_q;
    unique case (est_q)
      cfbp_pkg::CFBP_E_IDLE: est_d = enc_cmd_take ? cfbp_pkg::CFBP_E_PRE : est_q;
      cfbp_pkg::CFBP_E_PRE: est_d = buf_room ? cfbp_pkg::CFBP_E_HDR : est_q;
      cfbp_pkg::CFBP_E_HDR: est_d = !buf_room ? est_q : (eblk_q ? cfbp_pkg::CFBP_E_PAY : cfbp_pkg::CFBP_E_IDLE);
      cfbp_pkg::CFBP_E_PAY: est_d = (pay_take && enc_last) ? cfbp_pkg::CFBP_E_IDLE : est_q;
    endcase
  end

  // No end-of-sequence command exists here; block headers take enc_cmd_code unchecked
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      est_q <= cfbp_pkg::CFBP_E_IDLE;
      ecode_q <= 8'h00;
      ebw_q <= 16'h0000;
      eblk_q <= 1'b0;
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
      buf_q[0] <= 32'h00000000;
      buf_q[1] <= 32'h00000000;
      enc_cmd_ready_q <= 1'b0;
      enc_ready_q <= 1'b0;
    end else begin
      est_q <= est_d;
      if (enc_cmd_take) begin
        eblk_q <= (enc_cmd == cfbp_pkg::CFBP_CMD_BLOCK);
        ebw_q <= enc_cmd_bw;
        unique case (enc_cmd)
          cfbp_pkg::CFBP_CMD_FIELD1: ecode_q <= `CFBP_CODE_FIRST_FIELD_START_CODE;
          cfbp_pkg::CFBP_CMD_FIELD2: ecode_q <= `CFBP_CODE_SECOND_FIELD_START_CODE;
          default: ecode_q <= enc_cmd_code;
        endcase
      end
      if (wr) begin
        buf_q[wp_q] <= wr_word;
        wp_q <= !wp_q;
      end
      if (rd) begin
        rp_q <= !rp_q;
      end
      cnt_q <= cnt_d;
      enc_cmd_ready_q <= (est_d == cfbp_pkg::CFBP_E_IDLE) && enc_mode;
      enc_ready_q <= (est_d == cfbp_pkg::CFBP_E_PAY) && (cnt_d != 2'h2);
    end
  end
  assign link.d2h_data = buf_q[rp_q];
  assign link.d2h_valid = (cnt_q != 2'h0);
endmodule // cfbp_dev

//--- cfbp_host.sv
`timescale 1ns/100ps
`include "cfbp_cfg.svh"
module cfbp_host (
  input wire logic sys_clk,
  input wire logic resetn,
  cfbp_if.host link,
  input wire logic [`CFBP_WORD_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready_q,
  input wire logic tx_eos,
  output logic [`CFBP_WORD_W-1:0] rx_data_q,
  output logic rx_valid_q,
  input wire logic rx_ready
);
  // ----------------------------------------
  // Transmit path with sequence end
  // ----------------------------------------
  logic [`CFBP_WORD_W-1:0] h2d_data_q;
  logic h2d_valid_q;
  logic [1:0] eos_st_q;
  logic eos_req_q;
  wire slot_free = !h2d_valid_q || link.h2d_ready;
  wire tx_take = tx_valid && tx_ready_q;
  wire eos_go = slot_free && !tx_take && (eos_st_q != 2'h0);
  wire eos_arm = (eos_req_q || tx_eos) && (eos_st_q == 2'h0) && !tx_take;
  wire h2d_valid_d = tx_take || eos_go || (h2d_valid_q && !link.h2d_ready);
  wire [1:0] eos_st_d = eos_arm ? 2'h1 : (eos_go ? ((eos_st_q == 2'h1) ? 2'h2 : 2'h0) : eos_st_q);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      h2d_data_q <= 32'h00000000;
      h2d_valid_q <= 1'b0;
      eos_st_q <= 2'h0;
      eos_req_q <= 1'b0;
      tx_ready_q <= 1'b0;
    end else begin
      if (tx_take) begin
        h2d_data_q <= tx_data;
      end else if (eos_go) begin
        h2d_data_q <= (eos_st_q == 2'h1) ? `CFBP_PREFIX : `CFBP_EOS_TAIL;
      end
      h2d_valid_q <= h2d_valid_d;
      eos_st_q <= eos_st_d;
      eos_req_q <= (eos_req_q || tx_eos) && !eos_arm;
      tx_ready_q <= !h2d_valid_d && (eos_st_d == 2'h0) && !(eos_req_q || tx_eos);
    end
  end
  assign link.h2d_data = h2d_data_q;
  assign link.h2d_valid = h2d_valid_q;

  // ----------------------------------------
  // Receive path
  // ----------------------------------------
  logic d2h_ready_q;
  wire rx_take = link.d2h_valid && d2h_ready_q;
  wire rx_valid_d = rx_take || (rx_valid_q && !rx_ready);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_data_q <= 32'h00000000;
      rx_valid_q <= 1'b0;
      d2h_ready_q <= 1'b0;
    end else begin
      if (rx_take) begin
        rx_data_q <= link.d2h_data;
      end
      rx_valid_q <= rx_valid_d;
      d2h_ready_q <= !rx_valid_d;
    end
  end
  assign link.d2h_ready = d2h_ready_q;
endmodule // cfbp_host

//--- cfbp_if.sv
`timescale 1ns/100ps
`include "cfbp_cfg.svh"
interface cfbp_if;
  logic [`CFBP_WORD_W-1:0] h2d_data;
  logic h2d_valid;
  logic h2d_ready;
  logic [`CFBP_WORD_W-1:0] d2h_data;
  logic d2h_valid;
  logic d2h_ready;
  modport dev (
    input h2d_data, h2d_valid, d2h_ready,
    output h2d_ready, d2h_data, d2h_valid
  );
  modport host (
    output h2d_data, h2d_valid, d2h_ready,
    input h2d_ready, d2h_data, d2h_valid
  );
endinterface

//--- cfbp_link_asserts.sv
`timescale 1ns/100ps
`include "cfbp_cfg.svh"
module cfbp_link_asserts (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [`CFBP_WORD_W-1:0] h2d_data,
  input wire logic h2d_valid,
  input wire logic h2d_ready,
  input wire logic [`CFBP_WORD_W-1:0] d2h_data,
  input wire logic d2h_valid,
  input wire logic d2h_ready
);
  // --------------------------------
  // Word after an all-ones word
  // --------------------------------
  logic pref_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pref_q <= 1'b0;
    end else if (d2h_valid && d2h_ready) begin
      pref_q <= (d2h_data == `CFBP_PREFIX);
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // --------------------------------
  // Link properties
  // --------------------------------
  a_h2d_word_held: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
    else $error("host word changed before take");
  a_d2h_word_held: assert property (d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data))
    else $error("device word changed before take");
  a_h2d_ready_gap: assert property (h2d_valid && h2d_ready |=> !h2d_ready)
    else $error("device ready not dropped after take");
  a_d2h_ready_gap: assert property (d2h_valid && d2h_ready |=> !d2h_ready)
    else $error("host ready not dropped after take");
  a_no_seq_end: assert property (d2h_valid && pref_q |-> d2h_data != `CFBP_EOS_TAIL)
    else $error("device emitted sequence end");
  a_block_hdr_pad: assert property (d2h_valid && pref_q && d2h_data[31:28] == 4'h8
    |-> d2h_data[7:0] == `CFBP_PAD_BYTE)
    else $error("block header low byte not padded");
  a_field_hdr_zero: assert property (d2h_valid && pref_q && d2h_data[31:25] == 7'h20
    |-> d2h_data[23:0] == `CFBP_SOF_TAIL)
    else $error("field header tail not zero");
  a_reset_idle: assert property ($rose(resetn) |-> !d2h_valid && !h2d_valid)
    else $error("link busy right after reset");
endmodule // cfbp_link_asserts

//--- cfbp_pkg.sv
package cfbp_pkg;
  typedef enum logic [1:0] {
    CFBP_D_IDLE = 2'b00,
    CFBP_D_FIELD = 2'b01,
    CFBP_D_BLOCK = 2'b10,
    CFBP_D_ZERO = 2'b11
  } cfbp_dec_st_type;
  typedef enum logic [1:0] {
    CFBP_E_IDLE = 2'b00,
    CFBP_E_PRE = 2'b01,
    CFBP_E_HDR = 2'b10,
    CFBP_E_PAY = 2'b11
  } cfbp_enc_st_type;
  typedef enum logic [1:0] {
    CFBP_CMD_FIELD1 = 2'b00,
    CFBP_CMD_FIELD2 = 2'b01,
    CFBP_CMD_BLOCK = 2'b10
  } cfbp_cmd_type;
endpackage

//--- cfbp_tb.sv
`timescale 1ns/100ps
`include "cfbp_cfg.svh"
module cfbp_tb;
  localparam int FB = 3;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic enc_mode = 1'b0, huff_busy = 1'b0, dec_ready = 1'b1, rx_ready = 1'b1;
  logic enc_cmd_valid = 1'b0, enc_last = 1'b0, enc_valid = 1'b0, tx_valid = 1'b0, tx_eos = 1'b0;
  cfbp_pkg::cfbp_cmd_type enc_cmd = cfbp_pkg::CFBP_CMD_FIELD1;
  logic [7:0] enc_cmd_code = 8'h00;
  logic [15:0] enc_cmd_bw = 16'h0000, enc_cmd_recip = 16'h0000, quant_scale_q;
  logic [31:0] enc_data = 32'h00000000, tx_data = 32'h00000000, dec_data_q, rx_data_q;
  logic [5:0] enc_nbits = 6'h20, block_count_q;
  logic [2:0] block_model_q;
  logic dec_first_q, dec_valid_q, quant_load_q, block_start_q, block_zero_q, field_start_q, field_second_q;
  logic field_short_q, seq_end_q, huff_reset_q, enc_cmd_ready_q, enc_ready_q, tx_ready_q, rx_valid_q;
  logic [31:0] dq[$], bq[$], fq[$], rq[$], hq[$];
  int err_total = 0, total_checks = 0, cycles = 0, fs_n = 0, se_n = 0, hr_n = 0, sh_n = 0, ql_n = 0, seed;
  always #5 sys_clk = ~sys_clk;
  cfbp_if link_if ();
  cfbp_dev #(.FIELD_BLOCKS(FB)) cfbp_dev_i (.sys_clk(sys_clk), .resetn(resetn), .link(link_if),
    .enc_mode(enc_mode), .huff_busy(huff_busy), .dec_data_q(dec_data_q), .dec_first_q(dec_first_q),
    .dec_valid_q(dec_valid_q), .dec_ready(dec_ready), .quant_scale_q(quant_scale_q), .quant_load_q(quant_load_q),
    .block_model_q(block_model_q), .block_start_q(block_start_q), .block_zero_q(block_zero_q),
    .block_count_q(block_count_q), .field_start_q(field_start_q), .field_second_q(field_second_q),
    .field_short_q(field_short_q), .seq_end_q(seq_end_q), .huff_reset_q(huff_reset_q),
    .enc_cmd_valid(enc_cmd_valid), .enc_cmd(enc_cmd), .enc_cmd_code(enc_cmd_code), .enc_cmd_bw(enc_cmd_bw),
    .enc_cmd_recip(enc_cmd_recip), .enc_cmd_ready_q(enc_cmd_ready_q), .enc_data(enc_data),
    .enc_nbits(enc_nbits), .enc_last(enc_last), .enc_valid(enc_valid), .enc_ready_q(enc_ready_q));
  cfbp_host cfbp_host_i (.sys_clk(sys_clk), .resetn(resetn), .link(link_if), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready_q(tx_ready_q), .tx_eos(tx_eos), .rx_data_q(rx_data_q),
    .rx_valid_q(rx_valid_q), .rx_ready(rx_ready));
  cfbp_link_asserts cfbp_link_asserts_i (.sys_clk(sys_clk), .resetn(resetn), .h2d_data(link_if.h2d_data),
    .h2d_valid(link_if.h2d_valid), .h2d_ready(link_if.h2d_ready), .d2h_data(link_if.d2h_data),
    .d2h_valid(link_if.d2h_valid), .d2h_ready(link_if.d2h_ready));
  // --------------------------------
  // Checking and monitor
  // --------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic pop_cmp(ref logic [31:0] q[$], input logic [31:0] seen);
    check(seen, (q.size() > 0) ? q.pop_front() : 32'hXXXXXXXX);
  endtask
  task automatic summarize;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    if (resetn && !enc_mode) begin
      if (dec_valid_q && dec_ready && !dec_first_q) pop_cmp(dq, dec_data_q);
      if (dec_valid_q && dec_ready && dec_first_q) pop_cmp(hq, dec_data_q);
      if (block_start_q) pop_cmp(bq, {12'h000, block_zero_q, block_model_q, quant_scale_q});
      if (field_start_q) pop_cmp(fq, {31'h0, field_second_q});
      fs_n += field_start_q;
      se_n += seq_end_q;
      hr_n += huff_reset_q;
      sh_n += field_short_q;
    end
    if (resetn && rx_valid_q && rx_ready) pop_cmp(rq, rx_data_q);
    if (resetn) ql_n += quant_load_q;
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      summarize();
    end
  end
  always @(posedge sys_clk) begin
    #1;
    dec_ready = ($urandom_range(0, 3) != 0);
    rx_ready = ($urandom_range(0, 3) != 0);
  end
  // --------------------------------
  // Drivers
  // --------------------------------
  task automatic send(input logic [31:0] w);
    @(posedge sys_clk);
    #1 tx_data = w;
    tx_valid = 1'b1;
    do @(posedge sys_clk); while (!tx_ready_q);
    #1 tx_valid = 1'b0;
  endtask
  task automatic fstart(input logic sec);
    send(`CFBP_PREFIX);
    send({7'h20, sec, 24'h000000});
    fq.push_back({31'h0, sec});
  endtask
  task automatic dblk(input logic [7:0] code, input logic [15:0] bw, input int nw, input bit live);
    logic [31:0] w;
    logic zero;
    zero = (code == `CFBP_CODE_ZERO) || (bw == `CFBP_BW_ZERO);
    if (live && !zero) hq.push_back({code, bw, 8'h5A});
    send(`CFBP_PREFIX);
    send({code, bw, 8'h5A});
    if (live) bq.push_back({12'h000, zero, (code == `CFBP_CODE_ZERO) ? 3'h0 : code[2:0],
      (code == `CFBP_CODE_ZERO) ? 16'h0000 : bw});
    for (int i = 0; i < nw; i++) begin
      w = $urandom & 32'h7FFFFFFF;
      if (live && !zero) dq.push_back(w);
      send(w);
    end
  endtask
  task automatic eos;
    do @(posedge sys_clk); while (!tx_ready_q);
    #1 tx_eos = 1'b1;
    @(posedge sys_clk);
    #1 tx_eos = 1'b0;
  endtask
  task automatic ecmd(input cfbp_pkg::cfbp_cmd_type t, input logic [7:0] code, input logic [15:0] bw);
    logic [31:0] w;
    logic [15:0] rc;
    int nb;
    rc = 16'($urandom);
    nb = $urandom_range(1, 32);
    @(posedge sys_clk);
    #1 enc_cmd = t;
    enc_cmd_code = code;
    enc_cmd_bw = bw;
    enc_cmd_recip = rc;
    enc_cmd_valid = 1'b1;
    do @(posedge sys_clk); while (!enc_cmd_ready_q);
    #1 enc_cmd_valid = 1'b0;
    rq.push_back(`CFBP_PREFIX);
    if (t != cfbp_pkg::CFBP_CMD_BLOCK) rq.push_back({7'h20, t == cfbp_pkg::CFBP_CMD_FIELD2, 24'h000000});
    else begin
      rq.push_back({code, bw, `CFBP_PAD_BYTE});
      for (int i = 0; i < 2; i++) begin
        w = $urandom & 32'h7FFFFFFF;
        enc_data = w;
        enc_last = (i == 1);
        enc_nbits = 6'(nb);
        enc_valid = 1'b1;
        rq.push_back((i == 1) ? (w | (32'hFFFFFFFF >> nb)) : w);
        do @(posedge sys_clk); while (!enc_ready_q);
        #1;
      end
      enc_valid = 1'b0;
    end
    do @(posedge sys_clk); while (!enc_cmd_ready_q);
    if (t == cfbp_pkg::CFBP_CMD_BLOCK) check({16'h0000, quant_scale_q}, {16'h0000, rc});
  endtask
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    seed = $urandom(94);
    repeat (20) @(posedge sys_clk);
    #1 resetn = 1'b1;
    repeat (2) @(posedge sys_clk);
    check({31'h0, enc_cmd_ready_q}, 32'h00000000);
    fstart(1'b0);
    dblk(8'h82, 16'h0180, 2, 1'b1);
    // All-ones words not followed by a code are payload
    dq.push_back(`CFBP_PREFIX);
    dq.push_back(32'h12345678);
    dq.push_back(`CFBP_PREFIX);
    send(`CFBP_PREFIX);
    send(32'h12345678);
    send(`CFBP_PREFIX);
    dblk(`CFBP_CODE_ZERO, 16'($urandom), 1, 1'b1);
    dblk(8'h81, `CFBP_BW_ZERO, 1, 1'b1);
    repeat (30) @(posedge sys_clk);
    check({26'h0, block_count_q}, FB);
    eos();
    repeat (30) @(posedge sys_clk);
    dblk(8'h84, 16'h0200, 1, 1'b0);
    fstart(1'b1);
    repeat (30) @(posedge sys_clk);
    #1 huff_busy = 1'b1;
    dblk(8'h83, 16'($urandom_range(1, 65535)), 2, 1'b1);
    fstart(1'b0);
    eos();
    repeat (30) @(posedge sys_clk);
    #1 huff_busy = 1'b0;
    check(fs_n, 3);
    check(se_n, 2);
    check(hr_n, 5);
    check(sh_n, 2);
    enc_mode = 1'b1;
    repeat (4) @(posedge sys_clk);
    ecmd(cfbp_pkg::CFBP_CMD_FIELD1, 8'h00, 16'h0000);
    ecmd(cfbp_pkg::CFBP_CMD_FIELD2, 8'h00, 16'h0000);
    for (int c = 0; c < 5; c++) ecmd(cfbp_pkg::CFBP_CMD_BLOCK, (c == 4) ? `CFBP_CODE_ZERO : 8'(8'h81 + c),
      16'($urandom));
    repeat (40) @(posedge sys_clk);
    check(dq.size() + bq.size() + fq.size() + hq.size(), 0);
    check(ql_n, 9);
    check(rq.size(), 0);
    summarize();
  end
endmodule // cfbp_tb
